//--- design/scc_top.sv
/*
 * Conversion start/end sequencing for a six-channel simultaneous
 * sampling converter, with an APB register slave.
 * Assumes start and span pins are asynchronous, converter results
 * arrive on pclk and are stable when the conversion time expires.
 */
// Functional notes
// RULE_01 - Start A drives channels one and two, B three and four, C five and six, each pair together.
// RULE_02 - Each pair has its own start, so any mix of pairs, or all three tied, may be triggered.
// RULE_03 - A rising start edge puts that pair into hold and begins its conversion.
// RULE_04 - After a start edge busy goes high while the conversion runs.
// RULE_05 - The conversion is timed internally and lasts the conversion time from the start edge.
// RULE_06 - Busy drops once the conversion has finished.
// RULE_07 - The falling edge of busy returns the pairs to track, starting acquisition.
// RULE_08 - Span is taken from the pin or the span bits; 1 gives +/-2 x ref, 0 gives +/-4 x ref.
// RULE_09 - Results land in output registers readable by the controller.
// RULE_10 - The span pin is sampled at the falling edge of busy for the following conversion.
// RULE_11 - The controller reads results only after busy has gone low.
// RULE_12 - Reset aborts any conversion and clears the configuration register to zero.
// RULE_13 - Start edges seen while busy are ignored.
`timescale 1ns/1ps
module scc_top #(
    parameter int unsigned CONV_CYC = scc_pkg::TCONV_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [scc_pkg::APB_AW-1:0] paddr,
    input  wire logic [scc_pkg::APB_DW-1:0] pwdata,
    output logic      [scc_pkg::APB_DW-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       pair_a_start,
    input  wire logic                       pair_b_start,
    input  wire logic                       pair_c_start,
    input  wire logic                       span_select_bit,
    input  wire scc_pkg::scc_results_t      conv_result,
    output scc_pkg::scc_ctrl_t              conv_ctrl
);
    localparam int CW = $clog2(CONV_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CYC - 1);
    localparam int CONV_DLY = CONV_CYC;

    logic [3:0]                 sync_lvl;
    logic [3:0]                 sync_rise;
    scc_pkg::scc_state_t        state_r;
    scc_pkg::scc_ctrl_t         ctrl_r;
    scc_pkg::scc_cfg_t          cfg_r;
    logic [CW-1:0]              cnt_r;
    logic [scc_pkg::NPAIR-1:0]  fresh_r;
    logic [scc_pkg::RES_W-1:0]  res_r [scc_pkg::NCHAN];
    logic [scc_pkg::APB_DW-1:0] prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic                       setup_ok;
    logic                       wr_commit;
    logic                       rd_commit;
    logic                       is_ctrl;
    logic                       is_stat;
    logic                       is_res;
    logic [2:0]                 res_sel;
    logic [scc_pkg::APB_AW-1:0] res_off;
    logic                       abort;
    logic [scc_pkg::NPAIR-1:0]  go;
    logic                       start_ok;
    logic                       finish;
    logic [scc_pkg::APB_DW-1:0] rd_val;

    // Pins cross into pclk here
    scc_sync #(
        .W (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({span_select_bit, pair_c_start, pair_b_start, pair_a_start}),
        .sync_out (sync_lvl),
        .rise_out (sync_rise)
    );

    // APB phases: one wait state, commit when pready is seen
    assign setup_ok  = psel & penable & ~pready_r;
    assign wr_commit = psel & penable & pready_r & pwrite;
    assign rd_commit = psel & penable & pready_r & ~pwrite;

    // Address decode
    always_comb begin
        res_off = paddr - scc_pkg::RESULT_BASE;
        is_ctrl = (paddr == scc_pkg::CTRL_ADDR);
        is_stat = (paddr == scc_pkg::STATUS_ADDR);
        is_res  = (paddr >= scc_pkg::RESULT_BASE) && (paddr <= scc_pkg::RESULT_LAST)
                  && (paddr[1:0] == 2'b00);
        res_sel = res_off[4:2];
    end

    // Soft reset bit, self clearing
    assign abort = wr_commit & is_ctrl & pwdata[scc_pkg::CTRL_SRST_BIT]; // RULE_12

    // Pair selection: pins directly, or the software mask on any edge
    always_comb begin
        if (cfg_r.mode_sw) begin
            go = (|sync_rise[2:0]) ? cfg_r.pair_sel : '0; // RULE_02
        end else begin
            go = sync_rise[2:0]; // RULE_01
        end
    end

    // Edges during busy fall through: only idle accepts
    assign start_ok = (state_r == scc_pkg::SCC_IDLE) && (|go) && !abort; // RULE_13
    assign finish   = (state_r == scc_pkg::SCC_CONV) && (cnt_r == '0);

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= scc_pkg::SCC_IDLE;
            ctrl_r.busy <= 1'b0;
            ctrl_r.hold <= '0;
            cnt_r       <= '0;
        end else if (abort) begin
            state_r     <= scc_pkg::SCC_IDLE; // RULE_12
            ctrl_r.busy <= 1'b0;
            ctrl_r.hold <= '0;
            cnt_r       <= '0;
        end else begin
            unique case (state_r)
                scc_pkg::SCC_IDLE: begin
                    if (start_ok) begin
                        state_r     <= scc_pkg::SCC_CONV;
                        ctrl_r.busy <= 1'b1; // RULE_04
                        ctrl_r.hold <= go; // RULE_03
                        cnt_r       <= CNT_LAST; // RULE_05
                    end
                end
                scc_pkg::SCC_CONV: begin
                    if (finish) begin
                        state_r     <= scc_pkg::SCC_IDLE;
                        ctrl_r.busy <= 1'b0; // RULE_06
                        ctrl_r.hold <= '0; // RULE_07
                    end else begin
                        cnt_r <= cnt_r - 1'b1; // RULE_05
                    end
                end
            endcase
        end
    end

    // Span latched only as busy falls, so a change mid-conversion waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.span <= scc_pkg::SPAN_WIDE;
        end else if (finish && !abort) begin
            ctrl_r.span <= cfg_r.mode_sw ? cfg_r.span_sw : sync_lvl[3]; // RULE_10 RULE_08
        end
    end

    // Configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= scc_pkg::CFG_RST;
        end else if (abort) begin
            cfg_r <= scc_pkg::CFG_RST; // RULE_12
        end else if (wr_commit && is_ctrl) begin
            cfg_r.mode_sw  <= pwdata[scc_pkg::CTRL_MODE_BIT];
            cfg_r.pair_sel <= pwdata[scc_pkg::CTRL_PAIR_LSB +: scc_pkg::NPAIR];
            cfg_r.span_sw  <= pwdata[scc_pkg::CTRL_SPAN_BIT];
        end
    end

    // Result capture per channel, fresh flag per pair
    generate
        for (genvar c = 0; c < scc_pkg::NCHAN; c++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    res_r[c] <= '0;
                end else if (finish && !abort && ctrl_r.hold[c/2]) begin
                    res_r[c] <= conv_result.ch[c]; // RULE_09
                end
            end
        end
        for (genvar p = 0; p < scc_pkg::NPAIR; p++) begin : g_pair
            // Set wins over the read that clears it
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fresh_r[p] <= 1'b0;
                end else if (finish && !abort && ctrl_r.hold[p]) begin
                    fresh_r[p] <= 1'b1; // RULE_11
                end else if (rd_commit && is_res && res_sel == 3'(2 * p + 1)) begin
                    fresh_r[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_val = '0;
        if (is_ctrl) begin
            rd_val[scc_pkg::CTRL_MODE_BIT]                     = cfg_r.mode_sw;
            rd_val[scc_pkg::CTRL_PAIR_LSB +: scc_pkg::NPAIR]   = cfg_r.pair_sel;
            rd_val[scc_pkg::CTRL_SPAN_BIT]                     = cfg_r.span_sw;
        end else if (is_stat) begin
            rd_val[scc_pkg::STAT_BUSY_BIT]                     = ctrl_r.busy;
            rd_val[scc_pkg::STAT_HOLD_LSB +: scc_pkg::NPAIR]   = ctrl_r.hold;
            rd_val[scc_pkg::STAT_SPAN_BIT]                     = ctrl_r.span;
            rd_val[scc_pkg::STAT_FRESH_LSB +: scc_pkg::NPAIR]  = fresh_r;
        end else if (is_res) begin
            rd_val[scc_pkg::RES_W-1:0] = res_r[res_sel];
        end
    end

    // Registered APB answer, held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= setup_ok;
            pslverr_r <= setup_ok & ~(is_ctrl | is_stat | is_res);
            if (setup_ok && !pwrite) begin
                prdata_r <= rd_val;
            end
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign conv_ctrl = ctrl_r;

    property p_pair_map;
        @(posedge pclk) disable iff (!presetn)
        (start_ok && !cfg_r.mode_sw && sync_rise[0]) |=> conv_ctrl.hold[0];
    endproperty
    a_pair_map: assert property (p_pair_map) else $error("pair A start missed"); // RULE_01

    property p_sw_pairs;
        @(posedge pclk) disable iff (!presetn)
        (start_ok && cfg_r.mode_sw) |=> (conv_ctrl.hold == $past(cfg_r.pair_sel));
    endproperty
    a_sw_pairs: assert property (p_sw_pairs) else $error("software pair mask not held"); // RULE_02

    property p_hold_start;
        @(posedge pclk) disable iff (!presetn)
        (state_r == scc_pkg::SCC_IDLE && !abort && !cfg_r.mode_sw && |sync_rise[2:0])
            |=> (conv_ctrl.hold == $past(sync_rise[2:0]));
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("hold not set on start"); // RULE_03

    property p_busy_rise;
        @(posedge pclk) disable iff (!presetn)
        start_ok |=> conv_ctrl.busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised"); // RULE_04

    property p_conv_time;
        @(posedge pclk) disable iff (!presetn || abort)
        $rose(conv_ctrl.busy) |-> ##(CONV_DLY - 1) conv_ctrl.busy ##1 !conv_ctrl.busy;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong"); // RULE_05

    property p_busy_end;
        @(posedge pclk) disable iff (!presetn)
        (finish && !abort) |=> (!conv_ctrl.busy && state_r == scc_pkg::SCC_IDLE);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy did not drop"); // RULE_06

    property p_track;
        @(posedge pclk) disable iff (!presetn)
        $fell(conv_ctrl.busy) |-> (conv_ctrl.hold == '0);
    endproperty
    a_track: assert property (p_track) else $error("hold kept after busy fell"); // RULE_07

    property p_span_latch;
        @(posedge pclk) disable iff (!presetn)
        (finish && !abort && !cfg_r.mode_sw) |=> (conv_ctrl.span == $past(sync_lvl[3]));
    endproperty
    a_span_latch: assert property (p_span_latch) else $error("span not latched"); // RULE_10

    property p_result;
        @(posedge pclk) disable iff (!presetn)
        (finish && !abort && ctrl_r.hold[0]) |=> (res_r[0] == $past(conv_result.ch[0]));
    endproperty
    a_result: assert property (p_result) else $error("result not captured"); // RULE_09

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        abort |=> (!conv_ctrl.busy && conv_ctrl.hold == '0 && cfg_r == scc_pkg::CFG_RST);
    endproperty
    a_abort: assert property (p_abort) else $error("soft reset did not abort"); // RULE_12

    property p_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state_r == scc_pkg::SCC_CONV && !finish && !abort) |=> $stable(conv_ctrl.hold);
    endproperty
    a_ignore: assert property (p_ignore) else $error("start accepted while busy"); // RULE_13
endmodule

//--- include/scc_pkg.sv
/*
 * Constants, register map and carrier types for the simultaneous
 * conversion controller.
 * Assumes a single 10 MHz APB clock domain shared by all users.
 */
package scc_pkg;

    // Clock and conversion timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TCONV_NS      = 3000;
    // Longest time: round down, never below one cycle
    localparam int unsigned TCONV_RAW     = TCONV_NS / CLK_PERIOD_NS;
    localparam int unsigned TCONV_CYC     = (TCONV_RAW < 1) ? 1 : TCONV_RAW;

    // Structure sizes
    localparam int NPAIR  = 3;
    localparam int NCHAN  = 6;
    localparam int RES_W  = 16;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // Register byte addresses
    localparam logic [APB_AW-1:0] CTRL_ADDR   = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h004;
    localparam logic [APB_AW-1:0] RESULT_BASE = 12'h008;
    localparam logic [APB_AW-1:0] RESULT_LAST = 12'h01C;

    // Control register fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_PAIR_LSB = 1;
    localparam int CTRL_SPAN_BIT = 4;
    localparam int CTRL_SRST_BIT = 8;

    // Status register fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_HOLD_LSB  = 1;
    localparam int STAT_SPAN_BIT  = 4;
    localparam int STAT_FRESH_LSB = 8;

    // Span codes: 1 is +/-2 x ref, 0 is +/-4 x ref
    localparam logic SPAN_NARROW = 1'b1;
    localparam logic SPAN_WIDE   = 1'b0;

    typedef struct packed {
        logic             span_sw;
        logic [NPAIR-1:0] pair_sel;
        logic             mode_sw;
    } scc_cfg_t;

    localparam scc_cfg_t CFG_RST = '{span_sw: 1'b0, pair_sel: 3'h0, mode_sw: 1'b0};

    // Control toward the sampling stages
    typedef struct packed {
        logic             span;
        logic             busy;
        logic [NPAIR-1:0] hold;
    } scc_ctrl_t;

    // Raw results from the six converter cores
    typedef struct packed {
        logic [NCHAN-1:0][RES_W-1:0] ch;
    } scc_results_t;

    typedef enum logic {
        SCC_IDLE = 1'b0,
        SCC_CONV = 1'b1
    } scc_state_t;

endpackage

//--- design/scc_sync.sv
/*
 * Two-flop synchroniser with rising-edge detect, one per bit.
 * Assumes inputs are asynchronous levels that idle low.
 */
`timescale 1ns/1ps
module scc_sync #(
    parameter int W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out,
    output logic      [W-1:0] rise_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge taken between the settled stages
    assign sync_out = sync_r;
    assign rise_out = sync_r & ~prev_r;
endmodule

//--- dv/scc_host_model.sv
/*
 * Behavioural model of the controlling processor side: start pin pulses
 * and the converter core results presented to the controller.
 * Assumes the bench requests pulses with fire_go and keeps them spaced.
 */
`timescale 1ns/1ps
module scc_host_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [2:0]            fire_mask,
    input  wire logic                  fire_go,
    input  wire logic [11:0]           res_seed,
    output logic                       pair_a_start,
    output logic                       pair_b_start,
    output logic                       pair_c_start,
    output scc_pkg::scc_results_t      conv_result
);
    logic [1:0] hi_cnt_r;

    // Each pair pulsed on its own pin, any mix at once; three cycles high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pair_c_start, pair_b_start, pair_a_start} <= 3'h0;
            hi_cnt_r                                   <= 2'h0;
        end else if (fire_go) begin
            {pair_c_start, pair_b_start, pair_a_start} <= fire_mask;
            hi_cnt_r                                   <= 2'h3;
        end else if (hi_cnt_r != 2'h0) begin
            hi_cnt_r <= hi_cnt_r - 2'h1;
            if (hi_cnt_r == 2'h1) begin
                {pair_c_start, pair_b_start, pair_a_start} <= 3'h0;
            end
        end
    end

    // Core results: seed in the top bits, channel index below
    always_comb begin
        for (int i = 0; i < scc_pkg::NCHAN; i++) begin
            conv_result.ch[i] = {res_seed, 4'(i)};
        end
    end
endmodule

//--- dv/scc_top_tb.sv
/*
 * Self-checking bench for the conversion controller: APB register access,
 * pair starts, busy timing, span capture, refused starts and soft reset.
 * Assumes the host model drives the start pins and core results.
 */
`timescale 1ns/1ps
module scc_top_tb;
    // Full documented conversion length, so busy timing is judged against the real figure
    localparam int unsigned CONV = scc_pkg::TCONV_CYC;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                   span_pin, fire_go, pa, pb, pc, err;
    logic [11:0]            paddr, res_seed;
    logic [31:0]            pwdata, prdata, rd;
    logic [2:0]             fire_mask;
    scc_pkg::scc_results_t  conv_result;
    scc_pkg::scc_ctrl_t     conv_ctrl;
    int                     n_mismatch, checked, cycles, run, last_run;

    scc_top #(.CONV_CYC(CONV)) scc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pair_a_start(pa), .pair_b_start(pb),
        .pair_c_start(pc), .span_select_bit(span_pin), .conv_result(conv_result),
        .conv_ctrl(conv_ctrl));
    scc_host_model scc_host_model_inst (.pclk(pclk), .presetn(presetn), .fire_mask(fire_mask),
        .fire_go(fire_go), .res_seed(res_seed), .pair_a_start(pa), .pair_b_start(pb),
        .pair_c_start(pc), .conv_result(conv_result));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Busy run length, so starts fired mid-conversion cannot hide a restart
    always @(negedge pclk) begin
        if (conv_ctrl.busy === 1'b1) run <= run + 1;
        else if (run != 0) begin
            last_run <= run;
            run      <= 0;
        end
    end

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed wait count: only the hang guard ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
        check("slave error", 32'h0000_0000, {31'h0, err});
    endtask

    task automatic fire(input logic [2:0] m);
        @(posedge pclk);
        fire_mask <= m; fire_go <= 1'b1;
        @(posedge pclk);
        fire_go <= 1'b0;
    endtask

    // Start, check hold, optionally fire more starts, wait for the end
    task automatic run_conv(input logic [2:0] m, input logic [2:0] hold, input logic [2:0] late);
        int n;
        fire(m);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (conv_ctrl.busy !== 1'b1 && n < 20);
        check("busy rises", 32'h0000_0001, {31'h0, conv_ctrl.busy});
        check("hold pairs", {29'h0, hold}, {29'h0, conv_ctrl.hold});
        if (late != 3'h0) fire(late);
        n = 0;
        while (conv_ctrl.busy === 1'b1 && n < 60) begin
            @(negedge pclk);
            n++;
        end
        @(negedge pclk);
        check("busy length", CONV, last_run);
        check("busy falls", 32'h0000_0000, {31'h0, conv_ctrl.busy});
        check("hold released", 32'h0000_0000, {29'h0, conv_ctrl.hold});
    endtask

    // Read both results of a pair, after busy is low
    task automatic chk_pair(input int p);
        rd_chk("first result", scc_pkg::RESULT_BASE + 12'(8 * p),
            {16'h0, res_seed, 4'(2 * p)});
        rd_chk("second result", scc_pkg::RESULT_BASE + 12'(8 * p + 4),
            {16'h0, res_seed, 4'(2 * p + 1)});
    endtask

    task automatic t_reset();
        rd_chk("ctrl at reset", scc_pkg::CTRL_ADDR, 32'h0000_0000);
        rd_chk("status at reset", scc_pkg::STATUS_ADDR, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, err});
        check("unmapped data", 32'h0000_0000, rd);
        $display("test reset done");
    endtask

    task automatic t_pairs();
        for (int p = 0; p < 3; p++) begin
            res_seed <= 12'(12'h1A0 + p);
            run_conv(3'(1 << p), 3'(1 << p), 3'h0);
            rd_chk("fresh flag", scc_pkg::STATUS_ADDR, 32'(1 << (8 + p)));
            chk_pair(p);
        end
        res_seed <= 12'hABC;
        run_conv(3'h7, 3'h7, 3'h0);
        for (int p = 0; p < 3; p++) chk_pair(p);
        $display("test pairs done");
    endtask

    task automatic t_ignore();
        run_conv(3'h1, 3'h1, 3'h2);
        repeat (10) @(negedge pclk);
        check("no late start", 32'h0000_0000, {31'h0, conv_ctrl.busy});
        $display("test ignore done");
    endtask

    task automatic t_span();
        for (int s = 1; s >= 0; s--) begin
            @(posedge pclk);
            span_pin <= 1'(s);
            run_conv(3'h2, 3'h2, 3'h0);
            check("span after end", 32'(s), {31'h0, conv_ctrl.span});
            // Pair A stays fresh from the refused-start test, pair B from this one
            rd_chk("status span", scc_pkg::STATUS_ADDR, 32'(s << 4) | 32'h0000_0300);
            chk_pair(1);
        end
        $display("test span done");
    endtask

    task automatic t_soft();
        apb(1'b1, scc_pkg::CTRL_ADDR, 32'h0000_001D);
        rd_chk("ctrl readback", scc_pkg::CTRL_ADDR, 32'h0000_001D);
        run_conv(3'h1, 3'h6, 3'h0);
        check("span from bits", 32'h0000_0001, {31'h0, conv_ctrl.span});
        fire(3'h4);
        repeat (6) @(negedge pclk);
        check("busy before abort", 32'h0000_0001, {31'h0, conv_ctrl.busy});
        apb(1'b1, scc_pkg::CTRL_ADDR, 32'h0000_0100);
        @(negedge pclk);
        check("busy aborted", 32'h0000_0000, {31'h0, conv_ctrl.busy});
        check("hold aborted", 32'h0000_0000, {29'h0, conv_ctrl.hold});
        rd_chk("ctrl cleared", scc_pkg::CTRL_ADDR, 32'h0000_0000);
        $display("test soft reset done");
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; span_pin = 1'b0; fire_go = 1'b0; fire_mask = 3'h0;
        res_seed = 12'h000; n_mismatch = 0; checked = 0; cycles = 0; run = 0; last_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pairs();
        t_ignore();
        t_span();
        t_soft();
        end_sim();
    end
endmodule
